// ---- compressed_trace_output_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module compressed_trace_output_test;
  logic pclk, presetn, ev_valid, ev_kind, ev_exc, cpu_stall, trace_enable;
  logic realtime_mode, memory_mode, wrap_on_full, mem_req, mem_physical;
  logic mem_nocache, mem_ack, buffer_full, psel, penable, pwrite, pready;
  logic pslverr, err;
  logic [31:0] ev_addr, region_start, region_end, mem_addr, mem_wdata;
  logic [31:0] paddr, pwdata, prdata, rd, cnt;
  logic [31:0] wq[$];
  logic [31:0] dq[$];
  logic [31:0] ta [8] = '{32'h1234_5678, 32'h1234_567A, 32'h1234_56A0,
    32'h1234_9999, 32'h5678_0000, 32'h2000_0010, 32'h2000_0014, 32'h5678_0010};
  logic [3:0] tf [8] = '{4'h3, 4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h4, 4'h9};
  int n_errors, checks;
  cto_trace_if u_cto_trace_if ();
  cto_device u_cto_device (.pclk(pclk), .presetn(presetn),
    .ev_valid(ev_valid), .ev_kind(ev_kind), .ev_addr(ev_addr),
    .ev_next_addr(ev_addr + 32'h0000_0002), .ev_completion_exc(ev_exc),
    .cpu_stall(cpu_stall), .trace_enable(trace_enable),
    .realtime_mode(realtime_mode), .memory_mode(memory_mode),
    .wrap_on_full(wrap_on_full), .region_start(region_start),
    .region_end(region_end), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_physical(mem_physical),
    .mem_nocache(mem_nocache), .mem_ack(mem_ack), .buffer_full(buffer_full),
    .link(u_cto_trace_if.dev));
  cto_probe u_cto_probe (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(u_cto_trace_if.probe));
  cto_monitor mon (.pclk(pclk), .presetn(presetn),
    .trace_port_clock(u_cto_trace_if.trace_port_clock),
    .trace_valid(u_cto_trace_if.trace_valid),
    .trace_data(u_cto_trace_if.trace_data), .trace_enable(trace_enable),
    .realtime_mode(realtime_mode), .cpu_stall(cpu_stall),
    .buffer_full(buffer_full), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_addr(mem_addr), .mem_physical(mem_physical),
    .mem_nocache(mem_nocache), .region_start(region_start),
    .region_end(region_end));
  //////////////////////////////////////////////////////////////////////////
  // System bus slave that accepts every write one cycle after it is seen.
  always @(posedge pclk) begin
    mem_ack <= mem_req && !mem_ack;
    if (mem_req && mem_ack) begin
      wq.push_back(mem_addr);
      dq.push_back(mem_wdata);
    end
  end
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_cnt(input logic [31:0] t);
    rd = 'x;
    for (int i = 0; i < 200 && rd !== t; i++) apb(1'b0, 32'h0000_000C, '0);
    chk(rd === t, "record count");
  endtask : wait_cnt
  task automatic ev(input logic k, input logic [31:0] a, input logic x);
    @(posedge pclk);
    ev_valid <= 1'b1;
    ev_kind <= k;
    ev_addr <= a;
    ev_exc <= x;
  endtask : ev
  task automatic ev_end();
    @(posedge pclk);
    ev_valid <= 1'b0;
  endtask : ev_end
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, 32'h0000_0000, '0);
    chk(rd === 32'h0000_0001 && err === 1'b0, "ctrl reset");
    apb(1'b0, 32'h0000_0010, '0);
    chk(rd === 32'h0000_0000 && err === 1'b1, "unmapped");
  endtask : t_regs
  task automatic t_comp();
    for (int i = 0; i < 8; i++) begin
      ev(tf[i][2], ta[i], tf[i][3]);
      ev_end();
      cnt++;
      wait_cnt(cnt);
      apb(1'b0, 32'h0000_0004, '0);
      chk(rd[6:5] === tf[i][1:0] && rd[4] === tf[i][2], "len");
      chk(rd[1] === 1'b0, "partial");
      apb(1'b0, 32'h0000_0008, '0);
      chk(rd === ta[i] + (tf[i][3] ? 32'h0000_0002 : '0), "addr");
    end
  endtask : t_comp
  task automatic t_rt();
    ev(1'b0, 32'h1234_0000, 1'b0);
    ev(1'b0, 32'h1234_0004, 1'b0);
    ev_end();
    repeat (40) begin
      @(posedge pclk);
      chk(cpu_stall === 1'b0, "realtime stall");
    end
    cnt++;
    wait_cnt(cnt);
    repeat (100) @(posedge pclk);
    apb(1'b0, 32'h0000_000C, '0);
    chk(rd === cnt, "overlap not dropped");
  endtask : t_rt
  task automatic t_nrt();
    realtime_mode <= 1'b0;
    ev(1'b0, 32'h1234_0010, 1'b0);
    ev(1'b0, 32'h1234_0020, 1'b0);
    ev_end();
    #1;
    chk(cpu_stall === 1'b1, "no stall");
    cnt = cnt + 32'h0000_0002;
    wait_cnt(cnt);
    chk(cpu_stall === 1'b0, "stall stuck");
  endtask : t_nrt
  task automatic t_mem(input logic w);
    wrap_on_full <= w;
    memory_mode <= 1'b1;
    trace_enable <= 1'b0;
    repeat (3) @(posedge pclk);
    trace_enable <= 1'b1;
    wq.delete();
    dq.delete();
    for (int i = 0; i < 3; i++) begin
      ev(1'b1, 32'h3000_0040, 1'b0);
      ev_end();
      for (int j = 0; j < 99 && wq.size() < 2 * i + 2; j++) @(posedge pclk);
      repeat (5) @(posedge pclk);
    end
    chk(wq.size() === (w ? 6 : 4), "write count");
    for (int k = 0; k < wq.size(); k++)
      chk(wq[k] === 32'h055E_0000 + 32'(4 * (k % 4)), "wptr");
    chk(dq[0] === 32'h0000_0007, "header word");
    chk(dq[1] === 32'h3000_0040, "payload word");
    chk(buffer_full === !w, "full flag");
  endtask : t_mem
  //////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    {presetn, ev_valid, ev_kind, ev_exc, memory_mode, wrap_on_full} = '0;
    {mem_ack, psel, penable, pwrite, ev_addr, paddr, pwdata} = '0;
    {trace_enable, realtime_mode} = 2'h3;
    region_start = 32'h055E_0000;
    region_end = 32'h055E_000F;
    n_errors = 0;
    checks = 0;
    cnt = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_comp();
    t_rt();
    t_nrt();
    t_mem(1'b1);
    t_mem(1'b0);
    results();
  end
  initial begin
    #600000;
    n_errors++;
    results();
  end
endmodule : compressed_trace_output_test
`default_nettype wire

// ---- cto_device.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Branch sources sent as difference to last
// - Window addresses sent as difference to last
// - Upper 16 bits equal: send low 16
// - Upper 24 bits equal: send low 8
// - Upper 28 bits equal: send low 4
// - Probe rebuilds full address from partial bits
// - Realtime: never stall, drop overlapping record
// - Non-realtime: stall CPU until record is out
// - Wrap on full overwrites oldest record
// - Stop on full captures nothing more
// - Memory mode writes records between start, end once trace has been disabled; from reset the write pointer starts at 0
// - Software keeps region small and unshared
// - Memory writes are physical and uncached
// - Software places region in permitted RAM
// - Completion exception records following instruction address
// - Probe keeps trace port clock at most 50MHz
module cto_device (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Trace events from the CPU.
  input wire logic ev_valid,
  input wire logic ev_kind,
  input wire logic [31:0] ev_addr,
  input wire logic [31:0] ev_next_addr,
  input wire logic ev_completion_exc,
  output logic cpu_stall,
  // Configuration.
  input wire logic trace_enable,
  input wire logic realtime_mode,
  input wire logic memory_mode,
  input wire logic wrap_on_full,
  input wire logic [31:0] region_start,
  input wire logic [31:0] region_end,
  // System bus write port.
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic mem_physical,
  output logic mem_nocache,
  input wire logic mem_ack,
  output logic buffer_full,
  // Trace port.
  cto_trace_if.dev link
);

  typedef enum logic [1:0] {CTO_TX_IDLE, CTO_TX_BODY, CTO_TX_LAST} cto_tx_t;

  logic [1:0] base_ok_q;
  logic [31:0] prev_q [2];
  logic busy_q;
  logic pend_q;
  logic pend_kind_q;
  logic [31:0] pend_addr_q;
  logic rec_mem_q;
  cto_pkg::cto_rec_t rec_q;
  logic req_tog_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_s3_q;
  logic mem_req_q;
  logic word_q;
  logic full_q;
  logic [31:0] wptr_q;
  logic [31:0] mem_wdata_q;

  logic stopped;
  logic ev_fire;
  logic free_now;
  logic load_ev;
  logic load_pend;
  logic load;
  logic cap_pend;
  logic done;
  logic ld_kind;
  logic [31:0] ev_src;
  logic [31:0] ld_addr;
  logic [1:0] ld_len;
  logic word_done;
  logic at_end;
  logic [32:0] wnext;

  //////////////////////////////////////////////////////////////////////////
  // Event intake and compression.
  assign stopped = full_q & ~wrap_on_full;
  assign ev_src = ev_completion_exc ? ev_next_addr : ev_addr;
  assign ev_fire = ev_valid & trace_enable & ~pend_q & ~stopped;
  assign free_now = ~busy_q | (done & ~pend_q);
  assign load_ev = ev_fire & free_now;
  assign load_pend = done & pend_q;
  assign load = load_ev | load_pend;
  // A realtime event that finds the output busy is simply dropped.
  assign cap_pend = ev_fire & ~free_now & ~realtime_mode;
  assign ld_kind = load_pend ? pend_kind_q : ev_kind;
  assign ld_addr = load_pend ? pend_addr_q : ev_src;
  // Compression is against the last emitted address of the same kind.
  assign ld_len = cto_pkg::cto_len_code(prev_q[ld_kind], ld_addr,
                                        base_ok_q[ld_kind]);
  // Same encoder serves window trace through prev_q[1].

  assign wnext = {1'b0, wptr_q} + {1'b0, cto_pkg::CTO_WORD_STEP};
  assign at_end = (wnext + cto_pkg::CTO_WORD_TAIL) > {1'b0, region_end};
  assign word_done = mem_req_q & mem_ack;
  assign done = rec_mem_q ?
                (word_done & (word_q | (at_end & ~wrap_on_full))) :
                (ack_s2_q ^ ack_s3_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_ok_q <= 2'h0;
      prev_q[0] <= 32'h0000_0000;
      prev_q[1] <= 32'h0000_0000;
    end else if (!trace_enable) begin
      base_ok_q <= 2'h0;
    end else if (load) begin
      base_ok_q[ld_kind] <= 1'b1;
      prev_q[ld_kind] <= ld_addr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_q <= '0;
      rec_mem_q <= 1'b0;
    end else if (load) begin
      rec_q.kind <= ld_kind;
      rec_q.len <= ld_len;
      rec_q.payload <= ld_addr & cto_pkg::cto_mask(ld_len);
      rec_mem_q <= memory_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (load) begin
      busy_q <= 1'b1;
    end else if (done) begin
      busy_q <= 1'b0;
    end
  end

  // The held event keeps the CPU stopped until it is loaded for output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      pend_kind_q <= 1'b0;
      pend_addr_q <= 32'h0000_0000;
    end else if (load_pend) begin
      pend_q <= 1'b0;
    end else if (cap_pend) begin
      pend_q <= 1'b1;
      pend_kind_q <= ev_kind;
      pend_addr_q <= ev_src;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Memory output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req_q <= 1'b0;
      word_q <= 1'b0;
      mem_wdata_q <= 32'h0000_0000;
    end else if (load && memory_mode) begin
      mem_req_q <= 1'b1;
      word_q <= 1'b0;
      mem_wdata_q <= {28'h000_0000, 1'b0, ld_kind, ld_len};
    end else if (word_done) begin
      if (done) begin
        mem_req_q <= 1'b0;
      end else begin
        word_q <= 1'b1;
        mem_wdata_q <= rec_q.payload;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= 32'h0000_0000;
      full_q <= 1'b0;
    end else if (!trace_enable) begin
      wptr_q <= region_start;
      full_q <= 1'b0;
    end else if (word_done && at_end) begin
      if (wrap_on_full) begin
        wptr_q <= region_start;
      end else begin
        full_q <= 1'b1;
      end
    end else if (word_done) begin
      wptr_q <= wnext[31:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Handshake towards the trace port domain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_tog_q <= 1'b0;
    end else if (load && !memory_mode) begin
      req_tog_q <= ~req_tog_q;
    end
  end

  logic ack_tog_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tog_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
    end
  end

  assign cpu_stall = pend_q;
  assign mem_req = mem_req_q;
  assign mem_addr = wptr_q;
  assign mem_wdata = mem_wdata_q;
  assign buffer_full = full_q;

  // Memory trace writes never go through translation or the cache.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_physical <= 1'b1;
      mem_nocache <= 1'b1;
    end else begin
      mem_physical <= 1'b1;
      mem_nocache <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Trace port domain.
  logic lrst_s1_q;
  logic lrst_s2_q;
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  logic [31:0] sh_q;
  logic [2:0] cnt_q;
  cto_tx_t tx_q;

  always_ff @(posedge link.trace_port_clock or negedge presetn) begin
    if (!presetn) begin
      lrst_s1_q <= 1'b0;
      lrst_s2_q <= 1'b0;
    end else begin
      lrst_s1_q <= 1'b1;
      lrst_s2_q <= lrst_s1_q;
    end
  end

  always_ff @(posedge link.trace_port_clock or negedge lrst_s2_q) begin
    if (!lrst_s2_q) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      req_s1_q <= req_tog_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  // rec_q is stable from the toggle until the acknowledge returns.
  always_ff @(posedge link.trace_port_clock or negedge lrst_s2_q) begin
    if (!lrst_s2_q) begin
      tx_q <= CTO_TX_IDLE;
      link.trace_valid <= 1'b0;
      link.trace_data <= 4'h0;
      sh_q <= 32'h0000_0000;
      cnt_q <= 3'h0;
      ack_tog_q <= 1'b0;
    end else begin
      case (tx_q)
        CTO_TX_IDLE: begin
          if (req_s2_q ^ req_s3_q) begin
            link.trace_valid <= 1'b1;
            link.trace_data <= {1'b0, rec_q.kind, rec_q.len};
            sh_q <= rec_q.payload;
            cnt_q <= cto_pkg::cto_last_idx(rec_q.len);
            tx_q <= CTO_TX_BODY;
          end
        end
        CTO_TX_BODY: begin
          link.trace_data <= sh_q[3:0];
          sh_q <= {4'h0, sh_q[31:4]};
          if (cnt_q == 3'h0) begin
            tx_q <= CTO_TX_LAST;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        CTO_TX_LAST: begin
          link.trace_valid <= 1'b0;
          link.trace_data <= 4'h0;
          ack_tog_q <= ~ack_tog_q;
          tx_q <= CTO_TX_IDLE;
        end
        default: begin
          tx_q <= CTO_TX_IDLE;
        end
      endcase
    end
  end

endmodule : cto_device
`default_nettype wire

// ---- cto_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module cto_monitor (
  // Clocks and resets.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trace_port_clock,
  // Trace link.
  input wire logic trace_valid,
  input wire logic [3:0] trace_data,
  // Device side.
  input wire logic trace_enable,
  input wire logic realtime_mode,
  input wire logic cpu_stall,
  input wire logic buffer_full,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_addr,
  input wire logic mem_physical,
  input wire logic mem_nocache,
  input wire logic [31:0] region_start,
  input wire logic [31:0] region_end
);
  //////////////////////////////////////////////////////////////////////////
  AST_LEN4: assert property (@(posedge trace_port_clock)
    disable iff (!presetn) $rose(trace_valid) && trace_data[1:0] == 2'h0
    |-> trace_valid[*2] ##1 !trace_valid) else $error("bad 4-bit frame");
  AST_LEN8: assert property (@(posedge trace_port_clock)
    disable iff (!presetn) $rose(trace_valid) && trace_data[1:0] == 2'h1
    |-> trace_valid[*3] ##1 !trace_valid) else $error("bad 8-bit frame");
  AST_LEN16: assert property (@(posedge trace_port_clock)
    disable iff (!presetn) $rose(trace_valid) && trace_data[1:0] == 2'h2
    |-> trace_valid[*5] ##1 !trace_valid) else $error("bad 16-bit frame");
  AST_LEN32: assert property (@(posedge trace_port_clock)
    disable iff (!presetn) $rose(trace_valid) && trace_data[1:0] == 2'h3
    |-> trace_valid[*8] ##1 trace_valid ##1 !trace_valid)
    else $error("bad 32-bit frame");
  //////////////////////////////////////////////////////////////////////////
  AST_PHYS: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req |-> mem_physical && mem_nocache) else $error("write not physical");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("write dropped early");
  AST_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req && mem_ack ##1 mem_req |-> mem_addr == region_start
    || mem_addr == $past(mem_addr) + 32'h0000_0004) else $error("bad step");
  AST_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req |-> mem_addr >= region_start && mem_addr <= region_end)
    else $error("write outside region");
  AST_RT: assert property (@(posedge pclk) disable iff (!presetn)
    realtime_mode && !cpu_stall |=> !cpu_stall) else $error("realtime stall");
  AST_STALL: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cpu_stall) |-> ##[1:400] !cpu_stall) else $error("stall too long");
  AST_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    buffer_full && trace_enable |=> buffer_full) else $error("full lost");
  C_STALL: cover property (@(posedge pclk) $rose(cpu_stall));
  C_FULL: cover property (@(posedge pclk) $rose(buffer_full));
  C_SHORT: cover property (@(posedge trace_port_clock)
    $rose(trace_valid) && trace_data == 4'h0);
endmodule : cto_monitor
`default_nettype wire

// ---- cto_pkg.sv ----
`default_nettype none
package cto_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Record format.
  localparam logic [1:0] CTO_LEN4 = 2'h0;
  localparam logic [1:0] CTO_LEN8 = 2'h1;
  localparam logic [1:0] CTO_LEN16 = 2'h2;
  localparam logic [1:0] CTO_LEN32 = 2'h3;
  localparam logic CTO_KIND_BRANCH = 1'b0;
  localparam logic CTO_KIND_WINDOW = 1'b1;
  localparam logic [31:0] CTO_WORD_STEP = 32'h0000_0004;
  localparam logic [32:0] CTO_WORD_TAIL = 33'h0_0000_0003;

  typedef struct packed {
    logic kind;
    logic [1:0] len;
    logic [31:0] payload;
  } cto_rec_t;

  //////////////////////////////////////////////////////////////////////////
  // Probe registers, byte offsets on APB.
  localparam logic [7:0] CTO_OFF_CTRL = 8'h00;
  localparam logic [7:0] CTO_OFF_STATUS = 8'h04;
  localparam logic [7:0] CTO_OFF_ADDR = 8'h08;
  localparam logic [7:0] CTO_OFF_COUNT = 8'h0C;
  localparam int CTO_CTRL_RUN = 0;
  localparam int CTO_CTRL_REBASE = 1;
  localparam int CTO_ST_NEW = 0;
  localparam int CTO_ST_PARTIAL = 1;
  localparam int CTO_ST_BASE_BR = 2;
  localparam int CTO_ST_BASE_WIN = 3;
  localparam int CTO_ST_KIND = 4;
  localparam int CTO_ST_LEN = 5;
  localparam logic CTO_RUN_RST = 1'b1;

  //////////////////////////////////////////////////////////////////////////
  // Trace port clock.
  localparam int CTO_PCLK_MHZ = 125;
  localparam int CTO_LINK_MAX_MHZ = 50;
  localparam int CTO_DIV_HALF_DEF = 2;

  //////////////////////////////////////////////////////////////////////////
  // Shortest form that rebuilds addr from prev.
  function automatic logic [1:0] cto_len_code(input logic [31:0] prev,
                                             input logic [31:0] addr,
                                             input logic base_ok);
    if (!base_ok) return CTO_LEN32;
    if (prev[31:4] == addr[31:4]) return CTO_LEN4;
    if (prev[31:8] == addr[31:8]) return CTO_LEN8;
    if (prev[31:16] == addr[31:16]) return CTO_LEN16;
    return CTO_LEN32;
  endfunction : cto_len_code

  function automatic logic [2:0] cto_last_idx(input logic [1:0] len);
    case (len)
      CTO_LEN4: return 3'h0;
      CTO_LEN8: return 3'h1;
      CTO_LEN16: return 3'h3;
      default: return 3'h7;
    endcase
  endfunction : cto_last_idx

  function automatic logic [31:0] cto_mask(input logic [1:0] len);
    case (len)
      CTO_LEN4: return 32'h0000_000F;
      CTO_LEN8: return 32'h0000_00FF;
      CTO_LEN16: return 32'h0000_FFFF;
      default: return 32'hFFFF_FFFF;
    endcase
  endfunction : cto_mask

  function automatic logic [31:0] cto_merge(input logic [31:0] prev,
                                          input logic [31:0] payload,
                                          input logic [1:0] len);
    return (prev & ~cto_mask(len)) | (payload & cto_mask(len));
  endfunction : cto_merge

endpackage : cto_pkg
`default_nettype wire

// ---- cto_probe.sv ----
`timescale 1ns/1ps
`default_nettype none
module cto_probe #(
  parameter int DIV_HALF = cto_pkg::CTO_DIV_HALF_DEF
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trace port.
  cto_trace_if.probe link
);

  typedef enum logic {CTO_RX_IDLE, CTO_RX_BODY} cto_rx_t;

  // Trace port clock is pclk / (2 * DIV_HALF).
  if (DIV_HALF < 2 || DIV_HALF > 255 ||
      cto_pkg::CTO_PCLK_MHZ > 2 * DIV_HALF * cto_pkg::CTO_LINK_MAX_MHZ)
  begin : g_bad_div
    $error("DIV_HALF gives a trace port clock out of range");
  end

  localparam logic [7:0] LAST_CNT = 8'(DIV_HALF - 1);

  logic run_q;
  logic rebase_q;
  logic [7:0] div_q;
  logic clk_q;
  logic v_s1_q;
  logic v_s2_q;
  logic [3:0] d_s1_q;
  logic [3:0] d_s2_q;
  cto_rx_t rx_q;
  logic kind_q;
  logic [1:0] len_q;
  logic [2:0] idx_q;
  logic [31:0] acc_q;
  logic [31:0] last_q [2];
  logic [1:0] base_q;
  logic [31:0] addr_q;
  logic new_q;
  logic partial_q;
  logic [31:0] count_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  logic sample;
  logic rec_end;
  logic [31:0] payload;
  logic access;
  logic wr_ok;
  logic mapped;
  logic [31:0] status;
  logic [31:0] rd_mux;

  //////////////////////////////////////////////////////////////////////////
  // Trace port clock and input sampling.
  assign sample = run_q & (div_q == LAST_CNT) & ~clk_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
      clk_q <= 1'b0;
    end else if (!run_q) begin
      div_q <= 8'h00;
      clk_q <= 1'b0;
    end else if (div_q == LAST_CNT) begin
      div_q <= 8'h00;
      clk_q <= ~clk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign link.trace_port_clock = clk_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v_s1_q <= 1'b0;
      v_s2_q <= 1'b0;
      d_s1_q <= 4'h0;
      d_s2_q <= 4'h0;
    end else begin
      v_s1_q <= link.trace_valid;
      v_s2_q <= v_s1_q;
      d_s1_q <= link.trace_data;
      d_s2_q <= d_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Record reception and address rebuild.
  assign rec_end = sample & v_s2_q & (rx_q == CTO_RX_BODY) &
                   (idx_q == cto_pkg::cto_last_idx(len_q));
  always_comb begin
    payload = acc_q;
    payload[idx_q * 4 +: 4] = d_s2_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= CTO_RX_IDLE;
      kind_q <= 1'b0;
      len_q <= 2'h0;
      idx_q <= 3'h0;
      acc_q <= 32'h0000_0000;
    end else if (sample) begin
      case (rx_q)
        CTO_RX_IDLE: begin
          if (v_s2_q) begin
            kind_q <= d_s2_q[2];
            len_q <= d_s2_q[1:0];
            idx_q <= 3'h0;
            acc_q <= 32'h0000_0000;
            rx_q <= CTO_RX_BODY;
          end
        end
        CTO_RX_BODY: begin
          acc_q <= payload;
          idx_q <= idx_q + 3'h1;
          if (!v_s2_q || rec_end) begin
            rx_q <= CTO_RX_IDLE;
          end
        end
        default: begin
          rx_q <= CTO_RX_IDLE;
        end
      endcase
    end
  end

  // Without a full base only the difference can be reported.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q <= 2'h0;
      last_q[0] <= 32'h0000_0000;
      last_q[1] <= 32'h0000_0000;
      addr_q <= 32'h0000_0000;
      partial_q <= 1'b0;
      count_q <= 32'h0000_0000;
    end else if (rec_end) begin
      count_q <= count_q + 32'h0000_0001;
      if (base_q[kind_q] || len_q == cto_pkg::CTO_LEN32) begin
        base_q[kind_q] <= 1'b1;
        last_q[kind_q] <= cto_pkg::cto_merge(last_q[kind_q], payload, len_q);
        addr_q <= cto_pkg::cto_merge(last_q[kind_q], payload, len_q);
        partial_q <= 1'b0;
      end else begin
        addr_q <= payload & cto_pkg::cto_mask(len_q);
        partial_q <= 1'b1;
      end
    end else if (rebase_q) begin
      base_q <= 2'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // APB registers.
  assign access = psel & penable;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[31:4] == 28'h000_0000);
  assign wr_ok = access & pready_q & pwrite & mapped;

  always_comb begin
    status = 32'h0000_0000;
    status[cto_pkg::CTO_ST_NEW] = new_q;
    status[cto_pkg::CTO_ST_PARTIAL] = partial_q;
    status[cto_pkg::CTO_ST_BASE_BR] = base_q[0];
    status[cto_pkg::CTO_ST_BASE_WIN] = base_q[1];
    status[cto_pkg::CTO_ST_KIND] = kind_q;
    status[cto_pkg::CTO_ST_LEN +: 2] = len_q;
    case (paddr[7:0])
      cto_pkg::CTO_OFF_CTRL: rd_mux = {31'h0000_0000, run_q};
      cto_pkg::CTO_OFF_STATUS: rd_mux = status;
      cto_pkg::CTO_OFF_ADDR: rd_mux = addr_q;
      cto_pkg::CTO_OFF_COUNT: rd_mux = count_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (access && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= ~mapped;
      prdata_q <= (pwrite || !mapped) ? 32'h0000_0000 : rd_mux;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= cto_pkg::CTO_RUN_RST;
      rebase_q <= 1'b0;
    end else if (wr_ok && paddr[7:0] == cto_pkg::CTO_OFF_CTRL) begin
      run_q <= pwdata[cto_pkg::CTO_CTRL_RUN];
      rebase_q <= pwdata[cto_pkg::CTO_CTRL_REBASE];
    end else begin
      rebase_q <= 1'b0;
    end
  end

  // A record that ends in the clearing cycle keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      new_q <= 1'b0;
    end else if (rec_end) begin
      new_q <= 1'b1;
    end else if (wr_ok && paddr[7:0] == cto_pkg::CTO_OFF_STATUS &&
                 pwdata[cto_pkg::CTO_ST_NEW]) begin
      new_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule : cto_probe
`default_nettype wire

// ---- cto_trace_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface cto_trace_if;
  logic trace_port_clock;
  logic trace_valid;
  logic [3:0] trace_data;

  modport dev (
    input trace_port_clock,
    output trace_valid,
    output trace_data
  );

  modport probe (
    output trace_port_clock,
    input trace_valid,
    input trace_data
  );
endinterface : cto_trace_if
`default_nettype wire
